// >>> bench/cfrs_regs_tb.sv
// self-checking testbench of the cpu register set
`timescale 1ns/1ps
`default_nettype none
`include "cfrs_map.svh"

module cfrs_regs_tb
  import cfrs_pkg::*;
;
  localparam logic [7:0] IVEC = 8'h20;
  localparam logic [4:0] PSW  = `CFRS_OFS_PSW;
  localparam logic [4:0] ACC  = `CFRS_OFS_GEN;

  logic        clock_in       = 1'b0;
  logic        nrst_in        = 1'b0;
  logic [4:0]  addr_in        = 5'h00;
  logic [15:0] wdata_in       = 16'h0000;
  logic        wr_in          = 1'b0;
  logic        rd_in          = 1'b0;
  logic [15:0] rdata_out;
  logic        alu_valid_in   = 1'b0;
  cfrs_op_t    alu_op_in      = CFRS_OP_ADD;
  logic        alu_byte_in    = 1'b0;
  logic [2:0]  alu_dst_in     = 3'h0;
  logic [15:0] alu_src_in     = 16'h0000;
  logic        instr_done_in  = 1'b0;
  logic [3:0]  instr_len_in   = 4'h0;
  logic        jump_in        = 1'b0;
  logic [15:0] jump_target_in = 16'h0000;
  logic        str_step_in    = 1'b0;
  logic        str_word_in    = 1'b0;
  logic        intr_in        = 1'b0;
  cfrs_seg_t   seg_sel_in     = CFRS_SEG_EXTRA;
  logic [15:0] offset_in      = 16'h0000;
  logic [19:0] phys_addr_out;
  logic [15:0] psw_out;
  logic [15:0] ip_out;
  logic        step_trap_out;
  logic        irq_take_out;
  logic [7:0]  irq_vector_out;
  int          num_errors     = 0;
  int          checks         = 0;

  always #5 clock_in = ~clock_in;

  cfrs_regs #(.INTR_VECTOR(IVEC)) dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .alu_valid_in(alu_valid_in),
    .alu_op_in(alu_op_in), .alu_byte_in(alu_byte_in), .alu_dst_in(alu_dst_in),
    .alu_src_in(alu_src_in), .instr_done_in(instr_done_in), .instr_len_in(instr_len_in),
    .jump_in(jump_in), .jump_target_in(jump_target_in), .str_step_in(str_step_in),
    .str_word_in(str_word_in), .intr_in(intr_in), .seg_sel_in(seg_sel_in),
    .offset_in(offset_in), .phys_addr_out(phys_addr_out), .psw_out(psw_out),
    .ip_out(ip_out), .step_trap_out(step_trap_out), .irq_take_out(irq_take_out),
    .irq_vector_out(irq_vector_out)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clock_in);
    wr_in    <= 1'b0;
  endtask : bus_wr

  // read data only stand in the cycle after the strobe
  task automatic bus_rd(input logic [4:0] a, input logic [15:0] exp, input string what);
    @(posedge clock_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clock_in);
    rd_in   <= 1'b0;
    #1;
    chk(what, {4'h0, rdata_out}, {4'h0, exp});
  endtask : bus_rd

  task automatic alu(input cfrs_op_t op, input logic byt, input logic [2:0] dst, input logic [15:0] src);
    @(posedge clock_in);
    alu_op_in    <= op;
    alu_byte_in  <= byt;
    alu_dst_in   <= dst;
    alu_src_in   <= src;
    alu_valid_in <= 1'b1;
    @(posedge clock_in);
    alu_valid_in <= 1'b0;
    #1;
  endtask : alu

  task automatic done(input logic [3:0] len, input logic jmp, input logic [15:0] tgt);
    @(posedge clock_in);
    instr_len_in   <= len;
    jump_in        <= jmp;
    jump_target_in <= tgt;
    instr_done_in  <= 1'b1;
    @(posedge clock_in);
    instr_done_in  <= 1'b0;
    #1;
  endtask : done

  task automatic step(input logic wrd);
    @(posedge clock_in);
    str_word_in <= wrd;
    str_step_in <= 1'b1;
    @(posedge clock_in);
    str_step_in <= 1'b0;
  endtask : step

  task automatic phys(input cfrs_seg_t s, input logic [15:0] off, input logic [19:0] exp);
    @(posedge clock_in);
    seg_sel_in <= s;
    offset_in  <= off;
    @(posedge clock_in);
    #1;
    chk("phys_addr", phys_addr_out, exp);
  endtask : phys

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial
  begin
    #100000;
    num_errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    bus_rd(`CFRS_OFS_SEG + 5'h1, 16'hFFFF, "code_seg");
    bus_rd(`CFRS_OFS_SEG + 5'h3, 16'h0000, "data_seg");
    bus_rd(`CFRS_OFS_IP, 16'h0000, "ip");
    bus_rd(PSW, 16'h0000, "psw");
    bus_rd(5'h1F, 16'h0000, "unmapped");
    bus_wr(PSW, 16'hFFFF);
    bus_rd(PSW, 16'h0FD5, "psw_mask");
    bus_wr(PSW, 16'h0000);
    // word and byte views of one register
    bus_wr(ACC, 16'h1234);
    bus_rd(`CFRS_OFS_BYTE, 16'h0034, "acc_low");
    bus_rd(`CFRS_OFS_BYTE + 5'h4, 16'h0012, "acc_high");
    bus_wr(`CFRS_OFS_BYTE + 5'h4, 16'h00AB);
    bus_rd(ACC, 16'hAB34, "acc_word");
    // arithmetic flags, word then byte width
    bus_wr(ACC, 16'hFFFF);
    alu(CFRS_OP_ADD, 1'b0, 3'h0, 16'h0001);
    chk("psw_add", {4'h0, psw_out}, 20'h00055);
    bus_rd(ACC, 16'h0000, "acc_add");
    alu(CFRS_OP_SUB, 1'b0, 3'h0, 16'h0001);
    chk("psw_sub", {4'h0, psw_out}, 20'h00095);
    bus_wr(ACC, 16'h7FFF);
    alu(CFRS_OP_ADD, 1'b0, 3'h0, 16'h0001);
    chk("psw_ovf", {4'h0, psw_out}, 20'h00894);
    alu(CFRS_OP_ADD, 1'b1, 3'h0, 16'h00FF);
    chk("psw_byte", {4'h0, psw_out}, 20'h00084);
    alu(CFRS_OP_ADD, 1'b1, 3'h4, 16'h0080);
    chk("psw_byte_ovf", {4'h0, psw_out}, 20'h00845);
    bus_rd(ACC, 16'h00FF, "acc_byte");
    // logic operations clear carry and overflow
    bus_wr(5'h03, 16'hF0F0);
    alu(CFRS_OP_AND, 1'b0, 3'h3, 16'hFF00);
    chk("psw_and", {4'h0, psw_out}, 20'h00084);
    alu(CFRS_OP_OR, 1'b0, 3'h3, 16'h0001);
    chk("psw_or", {4'h0, psw_out}, 20'h00080);
    alu(CFRS_OP_XOR, 1'b0, 3'h3, 16'hF001);
    chk("psw_xor", {4'h0, psw_out}, 20'h00044);
    bus_rd(5'h03, 16'h0000, "base_xor");
    // address forming, with a wrap past one megabyte
    phys(CFRS_SEG_CODE, 16'h0010, 20'h00000);
    bus_wr(`CFRS_OFS_SEG + 5'h3, 16'h1234);
    phys(CFRS_SEG_DATA, 16'h5678, 20'h179B8);
    phys(CFRS_SEG_EXTRA, 16'hFFFF, 20'h0FFFF);
    bus_wr(`CFRS_OFS_SEG + 5'h2, 16'h0100);
    phys(CFRS_SEG_STACK, 16'h0020, 20'h01020);
    // string index stepping both ways
    bus_wr(5'h06, 16'h0010);
    bus_wr(5'h07, 16'h0020);
    bus_wr(PSW, 16'h0000);
    step(1'b0);
    bus_rd(5'h06, 16'h0011, "src_up");
    bus_rd(5'h07, 16'h0021, "dst_up");
    bus_wr(PSW, 16'h0400);
    step(1'b1);
    bus_rd(5'h06, 16'h000F, "src_down");
    bus_rd(5'h07, 16'h001F, "dst_down");
    // instruction pointer, trap ahead of a pending maskable request
    bus_wr(PSW, 16'h0300);
    intr_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    done(4'h3, 1'b0, 16'h0000);
    chk("step_trap", {19'h0, step_trap_out}, 20'h00001);
    chk("irq_first", {19'h0, irq_take_out}, 20'h00000);
    chk("vec_step", {12'h0, irq_vector_out}, 20'h00001);
    chk("psw_trap", {4'h0, psw_out}, 20'h00200);
    chk("ip_len", {4'h0, ip_out}, 20'h00003);
    done(4'h2, 1'b1, 16'h1000);
    chk("irq_take", {19'h0, irq_take_out}, 20'h00001);
    chk("vec_irq", {12'h0, irq_vector_out}, {12'h0, IVEC});
    chk("ip_jump", {4'h0, ip_out}, 20'h01000);
    chk("step_once", {19'h0, step_trap_out}, 20'h00000);
    bus_wr(PSW, 16'h0000);
    repeat (4) @(posedge clock_in);
    done(4'h4, 1'b0, 16'h0000);
    chk("irq_masked", {19'h0, irq_take_out}, 20'h00000);
    chk("ip_next", {4'h0, ip_out}, 20'h01004);
    // second reset in mid-run, with every reset target but the code segment away from its reset value
    bus_wr(`CFRS_OFS_SEG, 16'h00FF);
    bus_wr(PSW, 16'h0CD5);
    @(posedge clock_in);
    intr_in <= 1'b0;
    nrst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    nrst_in <= 1'b1;
    chk("psw2", {4'h0, psw_out}, 20'h00000);
    bus_rd(`CFRS_OFS_SEG + 5'h1, 16'hFFFF, "code_seg2");
    bus_rd(`CFRS_OFS_SEG + 5'h3, 16'h0000, "data_seg2");
    bus_rd(`CFRS_OFS_SEG + 5'h2, 16'h0000, "stack_seg2");
    bus_rd(`CFRS_OFS_SEG, 16'h0000, "extra_seg2");
    bus_rd(`CFRS_OFS_IP, 16'h0000, "ip2");
    bus_rd(ACC, 16'h00FF, "acc_kept");
    bus_rd(PSW, 16'h0000, "psw2_rd");
    close_out();
  end
endmodule : cfrs_regs_tb
`default_nettype wire

// >>> logic/cfrs_map.svh
// register offsets, flag positions and reset values of the cpu register set
`ifndef CFRS_MAP_SVH
`define CFRS_MAP_SVH
`define CFRS_OFS_GEN      5'h00
`define CFRS_OFS_SEG      5'h08
`define CFRS_OFS_IP       5'h0C
`define CFRS_OFS_PSW      5'h0D
`define CFRS_OFS_BYTE     5'h10
`define CFRS_BIT_CARRY    0
`define CFRS_BIT_PARITY   2
`define CFRS_BIT_AUX      4
`define CFRS_BIT_ZERO     6
`define CFRS_BIT_SIGN     7
`define CFRS_BIT_TRAP     8
`define CFRS_BIT_INTEN    9
`define CFRS_BIT_DIR      10
`define CFRS_BIT_OVF      11
`define CFRS_PSW_MASK     16'h0FD5
`define CFRS_RST_CODE_SEG 16'hFFFF
`define CFRS_RST_SEG      16'h0000
`define CFRS_RST_IP       16'h0000
`define CFRS_RST_PSW      16'h0000
`define CFRS_SEG_SHIFT    4
`define CFRS_STEP_VECTOR  8'h01
`endif

// >>> logic/cfrs_pkg.sv
// types shared by the cpu register set
`default_nettype none
package cfrs_pkg;
  typedef enum logic [2:0] {
    CFRS_OP_ADD = 3'h0,
    CFRS_OP_SUB = 3'h1,
    CFRS_OP_AND = 3'h2,
    CFRS_OP_OR  = 3'h3,
    CFRS_OP_XOR = 3'h4
  } cfrs_op_t;
  typedef enum logic [1:0] {
    CFRS_SEG_EXTRA = 2'h0,
    CFRS_SEG_CODE  = 2'h1,
    CFRS_SEG_STACK = 2'h2,
    CFRS_SEG_DATA  = 2'h3
  } cfrs_seg_t;
endpackage : cfrs_pkg
`default_nettype wire

// >>> logic/cfrs_regs.sv
// programmer-visible registers, status word and address former of the cpu
//
// Operation
// RULE1: carry flag in bit 0 is set on a carry out of or borrow into the top bit, else cleared.
// RULE2: parity flag in bit 2 is set when the low result byte has an even count of ones.
// RULE3: aux carry flag in bit 4 is set on carry out of or borrow into the low nibble.
// RULE4: zero flag in bit 6 is set when the result is zero, else cleared.
// RULE5: sign flag in bit 7 copies the top bit of the result.
// RULE6: with trap flag in bit 8 set, a single-step interrupt follows the next instruction and clears it.
// RULE7: with interrupt-enable in bit 9 set, a maskable request transfers control through its vector.
// RULE8: string steps decrement the index registers when direction flag in bit 10 is set, else increment.
// RULE9: overflow flag in bit 11 is set when the signed result does not fit the destination.
// RULE10: addresses are a 16-bit offset added to a 16-bit segment, reaching 1 MByte.
// RULE11: the four primary general registers are reachable as words or as two byte halves.
// RULE12: the instruction pointer holds the offset of the next sequential instruction.
// RULE13: the segment is shifted left four places before the offset is added, giving 20 bits.
// RULE14: reset loads code segment with all ones, other segments, pointer and status word with zero.
`timescale 1ns/1ps
`default_nettype none
`include "cfrs_map.svh"

module cfrs_regs
  import cfrs_pkg::*;
#(
  parameter logic [7:0] INTR_VECTOR = 8'h20
) (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic [4:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  input  wire logic        alu_valid_in,
  input  wire cfrs_op_t    alu_op_in,
  input  wire logic        alu_byte_in,
  input  wire logic [2:0]  alu_dst_in,
  input  wire logic [15:0] alu_src_in,
  input  wire logic        instr_done_in,
  input  wire logic [3:0]  instr_len_in,
  input  wire logic        jump_in,
  input  wire logic [15:0] jump_target_in,
  input  wire logic        str_step_in,
  input  wire logic        str_word_in,
  input  wire logic        intr_in,
  input  wire cfrs_seg_t   seg_sel_in,
  input  wire logic [15:0] offset_in,
  output logic      [19:0] phys_addr_out,
  output logic      [15:0] psw_out,
  output logic      [15:0] ip_out,
  output logic             step_trap_out,
  output logic             irq_take_out,
  output logic      [7:0]  irq_vector_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // general order: accumulator, count, data, base, stack ptr, base ptr, src idx, dst idx
  logic [15:0] gen_q [8];
  logic [15:0] gen_d [8];
  logic [15:0] seg_q [4];
  logic [15:0] seg_d [4];
  logic [15:0] ip_q, ip_d;
  logic [15:0] psw_q, psw_d;
  logic [15:0] rdata_q, rdata_d;
  logic [19:0] phys_q, phys_d;
  logic        step_q, step_d;
  logic        take_q, take_d;
  logic [7:0]  vec_q, vec_d;
  logic        intr_meta_q, intr_sync_q;

  function automatic logic even_parity(input logic [7:0] v);
    even_parity = ~(^v);
  endfunction : even_parity

  // byte halves: bit 2 picks the high half of one of the first four registers
  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
    byte_of = hi ? w[15:8] : w[7:0];
  endfunction : byte_of

  // ----------------------------------------------------------------
  // arithmetic and flags
  // ----------------------------------------------------------------
  logic [15:0] opa, opb, res;
  logic [16:0] wide;
  logic        msb_a, msb_b, msb_r, cout, aux, ovf, zero;

  always_comb
  begin
    opa = alu_byte_in ? {8'h00, byte_of(gen_q[{1'b0, alu_dst_in[1:0]}], alu_dst_in[2])}
                      : gen_q[alu_dst_in];
    opb = alu_byte_in ? {8'h00, alu_src_in[7:0]} : alu_src_in;
    unique case (alu_op_in)
      CFRS_OP_ADD: wide = {1'b0, opa} + {1'b0, opb};
      CFRS_OP_SUB: wide = {1'b0, opa} - {1'b0, opb};
      CFRS_OP_AND: wide = {1'b0, opa & opb};
      CFRS_OP_OR:  wide = {1'b0, opa | opb};
      CFRS_OP_XOR: wide = {1'b0, opa ^ opb};
      default:     wide = 17'h00000;
    endcase
    res   = alu_byte_in ? {8'h00, wide[7:0]} : wide[15:0];
    msb_a = alu_byte_in ? opa[7] : opa[15];
    msb_b = alu_byte_in ? opb[7] : opb[15];
    msb_r = alu_byte_in ? res[7] : res[15];
    if (alu_op_in == CFRS_OP_ADD || alu_op_in == CFRS_OP_SUB)
    begin
      cout = alu_byte_in ? (wide[8] ^ opa[8] ^ opb[8]) : wide[16]; // [RULE1]
      aux  = opa[4] ^ opb[4] ^ res[4]; // [RULE3]
      // add: like signs in, other sign out; sub: unlike signs in, sign of b out
      ovf  = (alu_op_in == CFRS_OP_ADD) ? (msb_a == msb_b) && (msb_r != msb_a)
                                        : (msb_a != msb_b) && (msb_r != msb_a); // [RULE9]
    end
    else
    begin
      cout = 1'b0;
      aux  = 1'b0;
      ovf  = 1'b0;
    end
    zero = (res == 16'h0000); // [RULE4]
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [15:0] idx_delta;

  always_comb
  begin
    gen_d   = gen_q;
    seg_d   = seg_q;
    ip_d    = ip_q;
    psw_d   = psw_q;
    step_d  = 1'b0;
    take_d  = 1'b0;
    vec_d   = vec_q;
    rdata_d = 16'h0000;
    idx_delta = str_word_in ? 16'h0002 : 16'h0001;

    if (alu_valid_in)
    begin
      if (alu_byte_in)
      begin
        if (alu_dst_in[2])
          gen_d[{1'b0, alu_dst_in[1:0]}][15:8] = res[7:0]; // [RULE11]
        else
          gen_d[{1'b0, alu_dst_in[1:0]}][7:0] = res[7:0]; // [RULE11]
      end
      else
        gen_d[alu_dst_in] = res;
      psw_d[`CFRS_BIT_CARRY]  = cout; // [RULE1]
      psw_d[`CFRS_BIT_PARITY] = even_parity(res[7:0]); // [RULE2]
      psw_d[`CFRS_BIT_AUX]    = aux; // [RULE3]
      psw_d[`CFRS_BIT_ZERO]   = zero; // [RULE4]
      psw_d[`CFRS_BIT_SIGN]   = msb_r; // [RULE5]
      psw_d[`CFRS_BIT_OVF]    = ovf; // [RULE9]
    end

    if (str_step_in)
    begin
      if (psw_q[`CFRS_BIT_DIR])
      begin
        gen_d[6] = gen_q[6] - idx_delta; // [RULE8]
        gen_d[7] = gen_q[7] - idx_delta; // [RULE8]
      end
      else
      begin
        gen_d[6] = gen_q[6] + idx_delta; // [RULE8]
        gen_d[7] = gen_q[7] + idx_delta; // [RULE8]
      end
    end

    if (instr_done_in)
    begin
      ip_d = jump_in ? jump_target_in : ip_q + {12'h000, instr_len_in}; // [RULE12]
      if (psw_q[`CFRS_BIT_TRAP])
      begin
        step_d = 1'b1; // [RULE6]
        vec_d  = `CFRS_STEP_VECTOR;
        psw_d[`CFRS_BIT_TRAP] = 1'b0; // [RULE6]
      end
      else if (intr_sync_q && psw_q[`CFRS_BIT_INTEN])
      begin
        take_d = 1'b1; // [RULE7]
        vec_d  = INTR_VECTOR;
      end
    end

    // software writes override the datapath in the same cycle
    if (wr_in)
    begin
      if ({addr_in[4:3], 3'h0} == `CFRS_OFS_GEN)
        gen_d[addr_in[2:0]] = wdata_in;
      else if ({addr_in[4:2], 2'h0} == `CFRS_OFS_SEG)
        seg_d[addr_in[1:0]] = wdata_in;
      else if (addr_in == `CFRS_OFS_IP)
        ip_d = wdata_in;
      else if (addr_in == `CFRS_OFS_PSW)
        psw_d = wdata_in & `CFRS_PSW_MASK;
      else if ({addr_in[4:3], 3'h0} == `CFRS_OFS_BYTE && !addr_in[2])
        gen_d[{1'b0, addr_in[1:0]}][7:0] = wdata_in[7:0]; // [RULE11]
      else if ({addr_in[4:3], 3'h0} == `CFRS_OFS_BYTE)
        gen_d[{1'b0, addr_in[1:0]}][15:8] = wdata_in[7:0]; // [RULE11]
    end

    if (rd_in)
    begin
      if ({addr_in[4:3], 3'h0} == `CFRS_OFS_GEN)
        rdata_d = gen_q[addr_in[2:0]];
      else if ({addr_in[4:2], 2'h0} == `CFRS_OFS_SEG)
        rdata_d = seg_q[addr_in[1:0]];
      else if (addr_in == `CFRS_OFS_IP)
        rdata_d = ip_q;
      else if (addr_in == `CFRS_OFS_PSW)
        rdata_d = psw_q;
      else if ({addr_in[4:3], 3'h0} == `CFRS_OFS_BYTE)
        rdata_d = {8'h00, byte_of(gen_q[{1'b0, addr_in[1:0]}], addr_in[2])}; // [RULE11]
    end

    // segment shifted four places then offset added, wraps at 1 MByte
    phys_d = {seg_q[seg_sel_in], 4'h0} + {4'h0, offset_in}; // [RULE10] [RULE13]
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // general registers keep their contents across reset
  always_ff @(posedge clock_in)
  begin
    gen_q <= gen_d;
  end

  always_ff @(posedge clock_in)
  begin
    intr_meta_q <= intr_in;
    intr_sync_q <= intr_meta_q;
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      seg_q[CFRS_SEG_EXTRA] <= `CFRS_RST_SEG; // [RULE14]
      seg_q[CFRS_SEG_CODE]  <= `CFRS_RST_CODE_SEG; // [RULE14]
      seg_q[CFRS_SEG_STACK] <= `CFRS_RST_SEG;
      seg_q[CFRS_SEG_DATA]  <= `CFRS_RST_SEG;
      ip_q    <= `CFRS_RST_IP;
      psw_q   <= `CFRS_RST_PSW;
      rdata_q <= 16'h0000;
      phys_q  <= 20'h00000;
      step_q  <= 1'b0;
      take_q  <= 1'b0;
      vec_q   <= 8'h00;
    end
    else
    begin
      seg_q   <= seg_d;
      ip_q    <= ip_d;
      psw_q   <= psw_d;
      rdata_q <= rdata_d;
      phys_q  <= phys_d;
      step_q  <= step_d;
      take_q  <= take_d;
      vec_q   <= vec_d;
    end
  end

  assign rdata_out      = rdata_q;
  assign phys_addr_out  = phys_q;
  assign psw_out        = psw_q;
  assign ip_out         = ip_q;
  assign step_trap_out  = step_q;
  assign irq_take_out   = take_q;
  assign irq_vector_out = vec_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);

  wire quiet = !wr_in;

  carry_word_a: assert property (alu_valid_in && !alu_byte_in && alu_op_in == CFRS_OP_ADD && quiet // [RULE1]
    |=> psw_q[`CFRS_BIT_CARRY] == ($past(gen_q[alu_dst_in]) + $past(alu_src_in) > 17'h0FFFF))
    else $error("carry flag wrong after word add");
  parity_low_a: assert property (alu_valid_in && quiet // [RULE2]
    |=> psw_q[`CFRS_BIT_PARITY] == ~(^$past(res[7:0])))
    else $error("parity flag wrong");
  aux_nibble_a: assert property (alu_valid_in && alu_op_in == CFRS_OP_ADD && quiet // [RULE3]
    |=> psw_q[`CFRS_BIT_AUX] == ($past(opa[3:0]) + $past(opb[3:0]) > 5'h0F))
    else $error("aux carry flag wrong");
  zero_result_a: assert property (alu_valid_in && quiet // [RULE4]
    |=> psw_q[`CFRS_BIT_ZERO] == ($past(res) == 16'h0000))
    else $error("zero flag wrong");
  sign_copy_a: assert property (alu_valid_in && !alu_byte_in && quiet // [RULE5]
    |=> psw_q[`CFRS_BIT_SIGN] == gen_q[$past(alu_dst_in)][15] || $past(str_step_in))
    else $error("sign flag does not follow result");
  trap_step_a: assert property (instr_done_in && psw_q[`CFRS_BIT_TRAP] && quiet // [RULE6]
    |=> step_trap_out && !psw_q[`CFRS_BIT_TRAP] ##1 !step_trap_out)
    else $error("single step not taken or trap not cleared");
  intr_masked_a: assert property (irq_take_out // [RULE7]
    |-> $past(psw_q[`CFRS_BIT_INTEN]) && $past(intr_sync_q) && irq_vector_out == INTR_VECTOR)
    else $error("interrupt taken while masked");
  string_dir_a: assert property (str_step_in && psw_q[`CFRS_BIT_DIR] && !alu_valid_in && quiet // [RULE8]
    |=> gen_q[6] == $past(gen_q[6]) - ($past(str_word_in) ? 16'h0002 : 16'h0001))
    else $error("index not decremented");
  ovf_add_a: assert property (alu_valid_in && !alu_byte_in && alu_op_in == CFRS_OP_ADD && quiet // [RULE9]
    |=> psw_q[`CFRS_BIT_OVF] == ($past(opa[15]) == $past(opb[15]) && $past(res[15]) != $past(opa[15])))
    else $error("overflow flag wrong");
  phys_form_a: assert property (nrst_in // [RULE10] [RULE13]
    |=> phys_addr_out == ({$past(seg_q[seg_sel_in]), 4'h0} + {4'h0, $past(offset_in)}))
    else $error("physical address wrong");
  ip_next_a: assert property (instr_done_in && !jump_in && quiet // [RULE12]
    |=> ip_q == $past(ip_q) + {12'h000, $past(instr_len_in)})
    else $error("instruction pointer not advanced");
  reset_seg_a: assert property (@(posedge clock_in) disable iff (1'b0) !nrst_in // [RULE14]
    |=> seg_q[CFRS_SEG_CODE] == 16'hFFFF && psw_q == 16'h0000 && ip_q == 16'h0000)
    else $error("reset values wrong");
  byte_half_a: assert property (wr_in && !alu_valid_in && addr_in == `CFRS_OFS_BYTE + 5'h04 // [RULE11]
    |=> gen_q[0][7:0] == $past(gen_q[0][7:0]) && gen_q[0][15:8] == $past(wdata_in[7:0]))
    else $error("byte write disturbed other half");

  step_seen_c: cover property (step_trap_out);
  intr_seen_c: cover property (irq_take_out);
  sub_borrow_c: cover property (alu_valid_in && alu_op_in == CFRS_OP_SUB && cout);
  byte_op_c: cover property (alu_valid_in && alu_byte_in && alu_dst_in[2]);

endmodule : cfrs_regs
`default_nettype wire
